// *** logic/acsw_pkg.sv ***
// Package with register map, field positions and constants of the channel status block.
package acsw_pkg;
  // ************************************************************
  // Register offsets (byte addresses, one word each)
  // ************************************************************
  localparam logic [5:0] OFF_STATUS0  = 6'h00;
  localparam logic [5:0] OFF_STATUS1  = 6'h04;
  localparam logic [5:0] OFF_VALUE0   = 6'h08;
  localparam logic [5:0] OFF_VALUE1   = 6'h0c;
  localparam logic [5:0] OFF_LIMIT1   = 6'h10;
  localparam logic [5:0] OFF_LIMIT2   = 6'h14;
  localparam logic [5:0] OFF_CTRL     = 6'h18;
  localparam logic [5:0] OFF_IRQ_STAT = 6'h1c;
  localparam logic [5:0] OFF_IRQ_MASK = 6'h20;
  localparam logic [5:0] OFF_OUT0     = 6'h24;
  localparam logic [5:0] OFF_OUT1     = 6'h28;
  // ************************************************************
  // Status word field positions
  // ************************************************************
  localparam int BIT_TOGGLE = 15;
  localparam int BIT_FAULT  = 14;
  localparam int BIT_SYNC   = 13;
  localparam int BIT_ERROR  = 6;
  localparam int LIM2_LSB   = 4;
  localparam int LIM1_LSB   = 2;
  localparam int BIT_OVER   = 1;
  localparam int BIT_UNDER  = 0;
  // ************************************************************
  // Control register fields and interrupt bits
  // ************************************************************
  localparam int CTRL_LIM1_EN = 0;
  localparam int CTRL_LIM2_EN = 1;
  localparam int CTRL_DC_EN   = 2;
  localparam int IRQ_W        = 4;
  localparam logic [1:0] CMP_OFF   = 2'h0;
  localparam logic [1:0] CMP_BELOW = 2'h1;
  localparam logic [1:0] CMP_ABOVE = 2'h2;
  localparam logic [1:0] CMP_EQUAL = 2'h3;
  localparam logic [15:0] RST_LIMIT = 16'h0000;
  localparam logic [15:0] RST_UPPER = 16'h7fff;
  localparam logic [15:0] RST_LOWER = 16'h8000;
  localparam logic [2:0]  RST_CTRL  = 3'h0;
  localparam logic [31:0] UNMAPPED  = 32'h00000000;
endpackage : acsw_pkg

// *** logic/acsw_channel.sv ***
// One input channel: builds its status word and holds its analog value.
`timescale 1ns/1ps
`default_nettype none
module acsw_channel (
  input  wire logic        ref_clk_in,
  input  wire logic        resetn_in,
  input  wire logic        sample_valid_in,
  input  wire logic [15:0] sample_in,
  input  wire logic        fault_in,
  input  wire logic        sync_fail_in,
  input  wire logic        cycle_end_in,
  input  wire logic        dc_en_in,
  input  wire logic        lim1_en_in,
  input  wire logic        lim2_en_in,
  input  wire logic [15:0] limit1_in,
  input  wire logic [15:0] limit2_in,
  input  wire logic [15:0] upper_in,
  input  wire logic [15:0] lower_in,
  output logic      [15:0] status_out,
  output logic      [15:0] value_out,
  output logic             range_evt_out
);
  typedef struct packed {
    logic        toggle;
    logic        sync_err;
    logic        sync_seen;
    logic        over;
    logic        under;
    logic [1:0]  lim1;
    logic [1:0]  lim2;
    logic [15:0] value;
  } acsw_ch_s;

  acsw_ch_s st;
  acsw_ch_s next_st;

  function automatic logic [1:0] cmp(input logic en, input logic [15:0] v,
                                     input logic [15:0] l);
    if (!en) begin
      cmp = acsw_pkg::CMP_OFF;
    end else if ($signed(v) < $signed(l)) begin
      cmp = acsw_pkg::CMP_BELOW;
    end else if ($signed(v) > $signed(l)) begin
      cmp = acsw_pkg::CMP_ABOVE;
    end else begin
      cmp = acsw_pkg::CMP_EQUAL;
    end
  endfunction

  always_comb begin
    next_st = st;
    if (sample_valid_in) begin
      next_st.toggle = ~st.toggle;
      next_st.value  = sample_in;
      next_st.over   = $signed(sample_in) > $signed(upper_in);
      next_st.under  = $signed(sample_in) < $signed(lower_in);
      next_st.lim1   = cmp(lim1_en_in, sample_in, limit1_in);
      next_st.lim2   = cmp(lim2_en_in, sample_in, limit2_in);
    end
    if (cycle_end_in) begin
      next_st.sync_err  = dc_en_in & (st.sync_seen | sync_fail_in);
      next_st.sync_seen = 1'b0;
    end else if (sync_fail_in) begin
      next_st.sync_seen = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    status_out = 16'h0000;
    status_out[acsw_pkg::BIT_TOGGLE] = st.toggle;
    status_out[acsw_pkg::BIT_FAULT] = fault_in;
    status_out[acsw_pkg::BIT_SYNC] = st.sync_err;
    status_out[acsw_pkg::BIT_ERROR] = st.over | st.under;
    status_out[acsw_pkg::LIM2_LSB +: 2] = st.lim2;
    status_out[acsw_pkg::LIM1_LSB +: 2] = st.lim1;
    status_out[acsw_pkg::BIT_OVER] = st.over;
    status_out[acsw_pkg::BIT_UNDER] = st.under;
  end

  assign value_out     = st.value;
  assign range_evt_out = sample_valid_in & (next_st.over | next_st.under);

  property p_toggle;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      sample_valid_in |=> (st.toggle != $past(st.toggle));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle did not flip");

  property p_value;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      sample_valid_in |=> (value_out == $past(sample_in));
  endproperty
  a_value: assert property (p_value) else $error("value not captured");

  property p_hold;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      !sample_valid_in |=> $stable(st.toggle);
  endproperty
  a_hold: assert property (p_hold) else $error("toggle moved without sample");

  property p_over;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      sample_valid_in && ($signed(sample_in) > $signed(upper_in)) |=> status_out[1];
  endproperty
  a_over: assert property (p_over) else $error("overrange not set");

  property p_under;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      sample_valid_in && ($signed(sample_in) < $signed(lower_in)) |=> status_out[0];
  endproperty
  a_under: assert property (p_under) else $error("underrange not set");

  property p_error;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      sample_valid_in && (($signed(sample_in) > $signed(upper_in)) ||
        ($signed(sample_in) < $signed(lower_in))) |=> status_out[6];
  endproperty
  a_error: assert property (p_error) else $error("error bit mismatch");

  property p_error_clr;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      sample_valid_in && ($signed(sample_in) <= $signed(upper_in)) &&
        ($signed(sample_in) >= $signed(lower_in)) |=> !status_out[6];
  endproperty
  a_error_clr: assert property (p_error_clr) else $error("error bit stuck");

  property p_lim1_off;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      sample_valid_in && !lim1_en_in |=> status_out[3:2] == 2'h0;
  endproperty
  a_lim1_off: assert property (p_lim1_off) else $error("limit1 not off");

  property p_lim2_eq;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      sample_valid_in && lim2_en_in && (sample_in == limit2_in) |=> status_out[5:4] == 2'h3;
  endproperty
  a_lim2_eq: assert property (p_lim2_eq) else $error("limit2 equal code wrong");

  sequence s_fail_then_end;
    sync_fail_in && !cycle_end_in ##1 (!sync_fail_in && cycle_end_in && dc_en_in);
  endsequence
  property p_sync;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      s_fail_then_end |=> status_out[13];
  endproperty
  a_sync: assert property (p_sync) else $error("sync error not reported");

  property p_zero;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      status_out[12:7] == 6'h00;
  endproperty
  a_zero: assert property (p_zero) else $error("unused bits not zero");

  property p_fault;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      fault_in |-> status_out[14];
  endproperty
  a_fault: assert property (p_fault) else $error("fault flag missing");
endmodule : acsw_channel
`default_nettype wire

// *** logic/acsw_top.sv ***
// Two-in two-out analog channel block with status words and Avalon-MM registers.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Per input status plus value; outputs value.
// - Status words go in input image.
// - Bit 15 toggles on each new value.
// - Bit 14 shows internal fault.
// - Bit 13 flags sync failure last cycle.
// - Bit 6 equals overrange or underrange.
// - Bits 5:4 second limit compare code.
// - Bits 3:2 first limit compare code.
// - Bit 1 set above upper threshold.
// - Bit 0 set below lower threshold.
// - No output control word is expected.
module acsw_top #(
  parameter int CH_N = 2
) (
  input  wire logic               ref_clk_in,
  input  wire logic               resetn_in,
  input  wire logic [5:0]         avs_address_in,
  input  wire logic               avs_read_in,
  input  wire logic               avs_write_in,
  input  wire logic [31:0]        avs_writedata_in,
  input  wire logic [3:0]         avs_byteenable_in,
  output logic      [31:0]        avs_readdata_out,
  output logic                    avs_waitrequest_out,
  input  wire logic [CH_N-1:0]    sample_valid_in,
  input  wire logic [CH_N*16-1:0] sample_in,
  input  wire logic [CH_N-1:0]    fault_in,
  input  wire logic               sync_fail_in,
  input  wire logic               cycle_end_in,
  input  wire logic [15:0]        upper_in,
  input  wire logic [15:0]        lower_in,
  input  wire logic [CH_N*16-1:0] out_value_in,
  input  wire logic               out_valid_in,
  output logic      [CH_N*32-1:0] process_image_out,
  output logic      [CH_N*16-1:0] dac_value_out,
  output logic                    irq_out
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [2:0]                          ctrl;
    logic [15:0]                         limit1;
    logic [15:0]                         limit2;
    logic [acsw_pkg::IRQ_W-1:0]          irq_stat;
    logic [acsw_pkg::IRQ_W-1:0]          irq_mask;
    logic [CH_N*16-1:0]                  dac;
    logic                                ack;
    logic [31:0]                         rdata;
  } acsw_top_s;

  acsw_top_s st;
  acsw_top_s next_st;

  logic [15:0]                 ch_status [CH_N];
  logic [15:0]                 ch_value  [CH_N];
  logic [CH_N-1:0]             range_evt;
  logic [acsw_pkg::IRQ_W-1:0]  evt;
  logic [31:0]                 rd_mux;
  logic [31:0]                 wmask;

  // ************************************************************
  // Channels
  // ************************************************************
  for (genvar i = 0; i < CH_N; i++) begin : g_ch
    acsw_channel u_ch (
      .ref_clk_in      (ref_clk_in),
      .resetn_in       (resetn_in),
      .sample_valid_in (sample_valid_in[i]),
      .sample_in       (sample_in[i*16 +: 16]),
      .fault_in        (fault_in[i]),
      .sync_fail_in    (sync_fail_in),
      .cycle_end_in    (cycle_end_in),
      .dc_en_in        (st.ctrl[acsw_pkg::CTRL_DC_EN]),
      .lim1_en_in      (st.ctrl[acsw_pkg::CTRL_LIM1_EN]),
      .lim2_en_in      (st.ctrl[acsw_pkg::CTRL_LIM2_EN]),
      .limit1_in       (st.limit1),
      .limit2_in       (st.limit2),
      .upper_in        (upper_in),
      .lower_in        (lower_in),
      .status_out      (ch_status[i]),
      .value_out       (ch_value[i]),
      .range_evt_out   (range_evt[i])
    );
    assign process_image_out[i*32 +: 32] = {ch_value[i], ch_status[i]};
  end

  // Event bits: 0 new sample, 1 range error, 2 fault, 3 sync failure.
  assign evt = {sync_fail_in & st.ctrl[acsw_pkg::CTRL_DC_EN], |fault_in, |range_evt,
                |sample_valid_in};

  always_comb begin
    wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
             {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
    unique case (avs_address_in)
      acsw_pkg::OFF_STATUS0:  rd_mux = {16'h0000, ch_status[0]};
      acsw_pkg::OFF_STATUS1:  rd_mux = {16'h0000, ch_status[CH_N-1]};
      acsw_pkg::OFF_VALUE0:   rd_mux = {16'h0000, ch_value[0]};
      acsw_pkg::OFF_VALUE1:   rd_mux = {16'h0000, ch_value[CH_N-1]};
      acsw_pkg::OFF_LIMIT1:   rd_mux = {16'h0000, st.limit1};
      acsw_pkg::OFF_LIMIT2:   rd_mux = {16'h0000, st.limit2};
      acsw_pkg::OFF_CTRL:     rd_mux = {29'h0, st.ctrl};
      acsw_pkg::OFF_IRQ_STAT: rd_mux = {28'h0, st.irq_stat};
      acsw_pkg::OFF_IRQ_MASK: rd_mux = {28'h0, st.irq_mask};
      acsw_pkg::OFF_OUT0:     rd_mux = {16'h0000, st.dac[15:0]};
      acsw_pkg::OFF_OUT1:     rd_mux = {16'h0000, st.dac[(CH_N-1)*16 +: 16]};
      default:                rd_mux = acsw_pkg::UNMAPPED;
    endcase
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_st = st;
    // One wait cycle per access; the ack pulse releases waitrequest.
    next_st.ack = (avs_read_in | avs_write_in) & ~st.ack;
    if (avs_read_in && !st.ack) begin
      next_st.rdata = rd_mux;
    end
    if (out_valid_in) begin
      next_st.dac = out_value_in;
    end
    // Writes land only on the edge that sees waitrequest low, so a stalled write has no effect.
    if (avs_write_in && st.ack) begin
      unique case (avs_address_in)
        acsw_pkg::OFF_LIMIT1: next_st.limit1 =
          (st.limit1 & ~wmask[15:0]) | (avs_writedata_in[15:0] & wmask[15:0]);
        acsw_pkg::OFF_LIMIT2: next_st.limit2 =
          (st.limit2 & ~wmask[15:0]) | (avs_writedata_in[15:0] & wmask[15:0]);
        acsw_pkg::OFF_CTRL: if (avs_byteenable_in[0]) begin
          next_st.ctrl = avs_writedata_in[2:0];
        end
        acsw_pkg::OFF_IRQ_STAT: if (avs_byteenable_in[0]) begin
          next_st.irq_stat = st.irq_stat & ~avs_writedata_in[acsw_pkg::IRQ_W-1:0];
        end
        acsw_pkg::OFF_IRQ_MASK: if (avs_byteenable_in[0]) begin
          next_st.irq_mask = avs_writedata_in[acsw_pkg::IRQ_W-1:0];
        end
        acsw_pkg::OFF_OUT0: if (!out_valid_in) begin
          next_st.dac[15:0] = avs_writedata_in[15:0];
        end
        acsw_pkg::OFF_OUT1: if (!out_valid_in) begin
          next_st.dac[(CH_N-1)*16 +: 16] = avs_writedata_in[15:0];
        end
        default: ;
      endcase
    end
    // Events set after the clear so that a set in the clearing cycle wins.
    next_st.irq_stat = next_st.irq_stat | evt;
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st        <= '0;
      st.ctrl   <= acsw_pkg::RST_CTRL;
      st.limit1 <= acsw_pkg::RST_LIMIT;
      st.limit2 <= acsw_pkg::RST_LIMIT;
    end else begin
      st <= next_st;
    end
  end

  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~st.ack;
  assign avs_readdata_out    = st.rdata;
  assign dac_value_out       = st.dac;
  assign irq_out             = |(st.irq_stat & st.irq_mask);

  // ************************************************************
  // Checks
  // ************************************************************
  property p_wait;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (avs_read_in && !st.ack) |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
  endproperty
  a_wait: assert property (p_wait) else $error("waitrequest timing wrong");

  property p_image;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      sample_valid_in[0] |=> process_image_out[acsw_pkg::BIT_TOGGLE] !=
        $past(process_image_out[acsw_pkg::BIT_TOGGLE]);
  endproperty
  a_image: assert property (p_image) else $error("status not in image");

  property p_image_hi;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      sample_valid_in[CH_N-1] |=>
        process_image_out[32*(CH_N-1) + acsw_pkg::BIT_TOGGLE] !=
        $past(process_image_out[32*(CH_N-1) + acsw_pkg::BIT_TOGGLE]);
  endproperty
  a_image_hi: assert property (p_image_hi) else $error("second status not in image");

  property p_dc_off;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      cycle_end_in && !st.ctrl[acsw_pkg::CTRL_DC_EN] |=>
        !process_image_out[acsw_pkg::BIT_SYNC];
  endproperty
  a_dc_off: assert property (p_dc_off) else $error("sync flag without enable");

  property p_write_late;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      avs_write_in && !st.ack |=> $stable(st.limit1) && $stable(st.ctrl);
  endproperty
  a_write_late: assert property (p_write_late) else $error("write landed while waiting");

  property p_dac;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      out_valid_in |=> dac_value_out == $past(out_value_in);
  endproperty
  a_dac: assert property (p_dac) else $error("output value not taken");

  property p_irq_set;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      sample_valid_in[0] |=> st.irq_stat[0];
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("event lost");
endmodule : acsw_top
`default_nettype wire

// *** test/acsw_ctrl_model.sv ***
// Model of the fieldbus controller that trades process data with the block.
`timescale 1ns/1ps
`default_nettype none
module acsw_ctrl_model (
  input  wire logic        ref_clk_in,
  input  wire logic        resetn_in,
  input  wire logic        send_in,
  input  wire logic [31:0] value_in,
  input  wire logic        cycle_end_in,
  input  wire logic [63:0] image_in,
  output logic      [31:0] out_value_out,
  output logic             out_valid_out,
  output logic      [63:0] image_seen_out
);
  // ************************************************************
  // Output direction
  // ************************************************************
  // values only, no command word.
  // Between strobes the lines flip every cycle, so a late sample shows up as a wrong value.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      out_value_out <= 32'h00000000;
      out_valid_out <= 1'b0;
    end else if (send_in) begin
      out_value_out <= value_in;
      out_valid_out <= 1'b1;
    end else begin
      out_value_out <= ~out_value_out;
      out_valid_out <= 1'b0;
    end
  end
  // ************************************************************
  // Input direction
  // ************************************************************
  // status taken from input image.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      image_seen_out <= 64'h0;
    end else if (cycle_end_in) begin
      image_seen_out <= image_in;
    end
  end
endmodule // acsw_ctrl_model
`default_nettype wire

// *** test/acsw_tb_top.sv ***
// Self-checking bench for the analog channel status block.
`timescale 1ns/1ps
`default_nettype none
module acsw_tb_top;
  // ************************************************************
  // Signals
  // ************************************************************
  typedef struct {
    logic [2:0]  ctrl;
    logic [15:0] smp;
    logic [15:0] up;
    logic [15:0] lo;
    logic [15:0] l1;
    logic [15:0] l2;
    logic [6:0]  exp;
  } acsw_row_s;
  logic        ref_clk_in = 1'b0;
  logic        resetn_in  = 1'b0;
  logic [5:0]  addr       = 6'h00;
  logic        rd         = 1'b0;
  logic        wr         = 1'b0;
  logic [31:0] wd         = 32'h0;
  logic [1:0]  smp_v      = 2'h0;
  logic [31:0] smp_d      = 32'h0;
  logic [1:0]  fault      = 2'h0;
  logic        sync_fail  = 1'b0;
  logic        cyc_end    = 1'b0;
  logic [15:0] upper      = 16'h7fff;
  logic [15:0] lower      = 16'h8000;
  logic        send       = 1'b0;
  logic [31:0] send_val   = 32'h0;
  logic [31:0] rdata, out_val, dac, q;
  logic [63:0] image, image_seen;
  logic        wait_req, out_vld, irq;
  logic [1:0]  tog        = 2'h0;
  logic [15:0] exp_sw;
  int          err_total  = 0;
  int          comparisons = 0;
  acsw_row_s   rows [8] = '{
    '{3'h3, 16'h0100, 16'h7fff, 16'h8000, 16'h0100, 16'h0200, 7'h1c},
    '{3'h3, 16'h0300, 16'h7fff, 16'h8000, 16'h0100, 16'h0200, 7'h28},
    '{3'h3, 16'h1001, 16'h1000, 16'h8000, 16'h0100, 16'h2000, 7'h5a},
    '{3'h1, 16'hff00, 16'h7fff, 16'h8000, 16'h0100, 16'h0200, 7'h04},
    '{3'h2, 16'h0200, 16'h7fff, 16'h8000, 16'h0100, 16'h0200, 7'h30},
    '{3'h0, 16'h1001, 16'h1000, 16'h8000, 16'h0100, 16'h0200, 7'h42},
    '{3'h0, 16'hefff, 16'h7fff, 16'hf000, 16'h0100, 16'h0200, 7'h41},
    '{3'h0, 16'h1000, 16'h1000, 16'h8000, 16'h0100, 16'h0200, 7'h00}};
  // ************************************************************
  // Design and controller model
  // ************************************************************
  acsw_top #(.CH_N(2)) i_dut (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(4'hf), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req),
    .sample_valid_in(smp_v), .sample_in(smp_d), .fault_in(fault),
    .sync_fail_in(sync_fail), .cycle_end_in(cyc_end), .upper_in(upper), .lower_in(lower),
    .out_value_in(out_val), .out_valid_in(out_vld), .process_image_out(image),
    .dac_value_out(dac), .irq_out(irq));
  acsw_ctrl_model i_ctrl (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .send_in(send), .value_in(send_val),
    .cycle_end_in(cyc_end), .image_in(image), .out_value_out(out_val),
    .out_valid_out(out_vld), .image_seen_out(image_seen));
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Holds the request until waitrequest is sampled low; the ack edge carries the read data.
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    addr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    @(posedge ref_clk_in);
    while (wait_req !== 1'b0 && n < 50) begin
      n++;
      @(posedge ref_clk_in);
    end
    if (n >= 50) err_total++;
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic sample(input int ch, input logic [15:0] v);
    @(posedge ref_clk_in);
    smp_d[ch*16 +: 16] <= v;
    smp_v[ch] <= 1'b1;
    @(posedge ref_clk_in);
    smp_v[ch] <= 1'b0;
    tog[ch] = ~tog[ch];
    @(negedge ref_clk_in);
  endtask
  task automatic dc_cycle(input logic fail);
    @(posedge ref_clk_in);
    sync_fail <= fail;
    @(posedge ref_clk_in);
    sync_fail <= 1'b0;
    cyc_end <= 1'b1;
    @(posedge ref_clk_in);
    cyc_end <= 1'b0;
    @(negedge ref_clk_in);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ************************************************************
  // Clock, watchdog and sequence
  // ************************************************************
  initial begin
    forever #20 ref_clk_in = ~ref_clk_in;
  end
  // The whole sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge ref_clk_in);
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    @(negedge ref_clk_in);
    check("image after reset", image[31:0] | image[63:32], 32'h0);
    bus(1'b0, acsw_pkg::OFF_CTRL, 32'h0);
    check("ctrl reset", q, {29'h0, acsw_pkg::RST_CTRL});
    bus(1'b0, acsw_pkg::OFF_LIMIT1, 32'h0);
    check("limit1 reset", q, {16'h0, acsw_pkg::RST_LIMIT});
    bus(1'b0, 6'h3c, 32'h0);
    check("unmapped read", q, acsw_pkg::UNMAPPED);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk_in);
      upper <= rows[i].up;
      lower <= rows[i].lo;
      bus(1'b1, acsw_pkg::OFF_LIMIT1, {16'h0, rows[i].l1});
      bus(1'b1, acsw_pkg::OFF_LIMIT2, {16'h0, rows[i].l2});
      bus(1'b1, acsw_pkg::OFF_CTRL, {29'h0, rows[i].ctrl});
      sample(i % 2, rows[i].smp);
      exp_sw = {tog[i % 2], 2'h0, 6'h00, rows[i].exp};
      check("status word", {16'h0, image[(i%2)*32 +: 16]}, {16'h0, exp_sw});
      check("analog value", {16'h0, image[(i%2)*32+16 +: 16]}, {16'h0, rows[i].smp});
      bus(1'b0, (i % 2) ? acsw_pkg::OFF_STATUS1 : acsw_pkg::OFF_STATUS0, 32'h0);
      check("status register", q, {16'h0, exp_sw});
    end
    $display("test rows done");
    @(posedge ref_clk_in);
    upper <= 16'h7fff;
    lower <= 16'h8000;
    bus(1'b1, acsw_pkg::OFF_CTRL, 32'h4);
    dc_cycle(1'b1);
    check("sync flag set", {31'h0, image[acsw_pkg::BIT_SYNC]}, 32'h1);
    dc_cycle(1'b0);
    check("sync flag clear", {31'h0, image[acsw_pkg::BIT_SYNC]}, 32'h0);
    check("controller view", {31'h0, image_seen[acsw_pkg::BIT_SYNC]}, 32'h1);
    bus(1'b1, acsw_pkg::OFF_CTRL, 32'h0);
    dc_cycle(1'b1);
    check("sync flag off", {31'h0, image[acsw_pkg::BIT_SYNC]}, 32'h0);
    $display("test sync done");
    bus(1'b1, acsw_pkg::OFF_IRQ_MASK, 32'h0);
    bus(1'b1, acsw_pkg::OFF_IRQ_STAT, 32'hf);
    sample(0, 16'h0010);
    bus(1'b0, acsw_pkg::OFF_IRQ_STAT, 32'h0);
    check("irq status", q, 32'h1);
    check("irq masked", {31'h0, irq}, 32'h0);
    bus(1'b1, acsw_pkg::OFF_IRQ_MASK, 32'h1);
    @(negedge ref_clk_in);
    check("irq raised", {31'h0, irq}, 32'h1);
    bus(1'b1, acsw_pkg::OFF_IRQ_STAT, 32'h1);
    @(negedge ref_clk_in);
    check("irq cleared", {31'h0, irq}, 32'h0);
    $display("test irq done");
    @(posedge ref_clk_in);
    fault <= 2'h2;
    @(negedge ref_clk_in);
    check("fault ch1", {31'h0, image[32 + acsw_pkg::BIT_FAULT]}, 32'h1);
    check("fault ch0", {31'h0, image[acsw_pkg::BIT_FAULT]}, 32'h0);
    @(posedge ref_clk_in);
    fault <= 2'h0;
    @(negedge ref_clk_in);
    check("fault gone", {31'h0, image[32 + acsw_pkg::BIT_FAULT]}, 32'h0);
    $display("test fault done");
    @(posedge ref_clk_in);
    send <= 1'b1;
    send_val <= 32'habcd1234;
    @(posedge ref_clk_in);
    send <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    check("output values", dac, 32'habcd1234);
    bus(1'b1, acsw_pkg::OFF_OUT0, 32'h5555);
    @(negedge ref_clk_in);
    check("output by bus", dac, 32'habcd5555);
    bus(1'b1, acsw_pkg::OFF_OUT1, 32'h7777);
    bus(1'b0, acsw_pkg::OFF_OUT1, 32'h0);
    check("out1 readback", q, 32'h7777);
    check("out1 by bus", dac, 32'h77775555);
    $display("test output done");
    @(posedge ref_clk_in);
    resetn_in <= 1'b0;
    @(negedge ref_clk_in);
    check("image in reset", image[31:0] | image[63:32], 32'h0);
    @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    $display("test second reset done");
    end_of_test();
  end
endmodule // acsw_tb_top
`default_nettype wire
